// *** include/bbf_pkg.sv ***
package bbf_pkg;

  // Clock and bus-cycle timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SETUP_NS    = 100;
  localparam int T_PULSE_NS    = 200;
  localparam int T_HOLD_NS     = 100;
  // Least times round up to whole cycles
  localparam logic [2:0] SETUP_CYC = 3'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] PULSE_CYC = 3'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] HOLD_CYC  = 3'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] SYNC_CYC  = 3'h2;

  // Flash command codes
  localparam logic [7:0] CODE_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CODE_READ_STATUS = 8'h70;
  localparam logic [7:0] CODE_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CODE_READ_ID     = 8'h90;
  localparam logic [7:0] CODE_PROGRAM     = 8'h40;
  localparam logic [7:0] CODE_ERASE       = 8'h20;
  localparam logic [7:0] CODE_CONFIRM     = 8'hd0;
  localparam logic [7:0] CODE_SUSPEND     = 8'hb0;

  // Device status byte fields
  localparam int READY_BIT      = 7;
  localparam int SUSPEND_BIT    = 6;
  localparam int ERASE_ERR_BIT  = 5;
  localparam int PROG_ERR_BIT   = 4;

  // Boot-block map limits
  localparam logic [19:0] BOOT_BOT_BYTE_END = 20'h03fff;
  localparam logic [19:0] BOOT_BOT_WORD_END = 20'h01fff;
  localparam logic [19:0] BOOT_TOP_BYTE_BEG = 20'hfc000;
  localparam logic [19:0] BOOT_TOP_WORD_BEG = 20'h7e000;
  localparam logic [19:0] WORD_ADDR_MASK    = 20'h7ffff;

  // APB register offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CONFIG = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;

  // Config fields and reset value
  localparam int CFG_RP_N    = 0;
  localparam int CFG_WP_N    = 1;
  localparam int CFG_HV      = 2;
  localparam int CFG_TOP     = 3;
  localparam int CFG_BYTE    = 4;
  localparam int CFG_V12     = 5;
  localparam int CFG_W       = 6;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // Status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_JOB      = 1;
  localparam int ST_REFUSED  = 2;
  localparam int ST_LOCKED   = 3;
  localparam int ST_BYTE_LSB = 8;

  // Software operations written to the command register
  localparam logic [3:0] OP_READ_ARRAY  = 4'h1;
  localparam logic [3:0] OP_READ_STATUS = 4'h2;
  localparam logic [3:0] OP_CLR_STATUS  = 4'h3;
  localparam logic [3:0] OP_READ_ID     = 4'h4;
  localparam logic [3:0] OP_PROGRAM     = 4'h5;
  localparam logic [3:0] OP_ERASE       = 4'h6;
  localparam logic [3:0] OP_SUSPEND     = 4'h7;
  localparam logic [3:0] OP_RESUME      = 4'h8;

  typedef enum logic [1:0] {
    CY_IDLE   = 2'b00,
    CY_SETUP  = 2'b01,
    CY_STROBE = 2'b11,
    CY_HOLD   = 2'b10
  } bbf_cycle_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_WR1  = 3'b001,
    M_WR2  = 3'b011,
    M_RD   = 3'b010
  } bbf_main_e;

endpackage : bbf_pkg

// *** verilog/bbf_bus_cycle.sv ***
`timescale 1ns/100ps
module bbf_bus_cycle
  import bbf_pkg::*;
(
  input  logic        ref_clk,
  input  logic        rst,
  input  logic        start,
  input  logic        write,
  input  logic [19:0] addr,
  input  logic [15:0] wdata,
  output logic        done,
  output logic [15:0] rdata,
  output logic        ce_n,
  output logic        oe_n,
  output logic        we_n,
  output logic [19:0] flash_addr,
  output logic [15:0] dq_out,
  output logic        dq_oe,
  input  logic [15:0] dq_in
);

  bbf_cycle_e  state;
  bbf_cycle_e  next_state;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic        wr;
  logic        next_wr;
  logic [19:0] next_flash_addr;
  logic [15:0] next_dq_out;
  logic [15:0] next_rdata;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;
  logic [2:0]  strobe_len;

  // Reads stretch the strobe so the synchronised data is settled
  assign strobe_len = wr ? PULSE_CYC : 3'(PULSE_CYC + SYNC_CYC);

  // Pin strobes decoded from state; each cycle deasserts them again
  always_comb
  begin
    ce_n  = !(state == CY_STROBE);
    oe_n  = !(state == CY_STROBE && !wr);
    we_n  = !(state == CY_STROBE && wr);
    dq_oe = wr && (state != CY_IDLE);
    done  = (state == CY_HOLD) && (cnt == HOLD_CYC);
  end

  // Next-state logic for one bus cycle
  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt + 3'h1;
    next_wr         = wr;
    next_flash_addr = flash_addr;
    next_dq_out     = dq_out;
    next_rdata      = rdata;
    case (state)
      CY_IDLE:
      begin
        next_cnt = 3'h1;
        if (start)
        begin
          next_state      = CY_SETUP;
          next_wr         = write;
          next_flash_addr = addr;
          next_dq_out     = write ? wdata : 16'h0000;
        end
      end
      CY_SETUP:
        if (cnt == SETUP_CYC)
        begin
          next_state = CY_STROBE;
          next_cnt   = 3'h1;
        end
      CY_STROBE:
        if (cnt == strobe_len)
        begin
          next_state = CY_HOLD;
          next_cnt   = 3'h1;
          if (!wr)
            next_rdata = dq_sync;
        end
      CY_HOLD:
        if (cnt == HOLD_CYC)
          next_state = CY_IDLE;
      default:
        next_state = CY_IDLE;
    endcase
  end

  // Registers, including the two-stage data synchroniser
  always_ff @(posedge ref_clk)
  begin
    dq_meta <= dq_in;
    dq_sync <= dq_meta;
    if (rst)
    begin
      state      <= CY_IDLE;
      cnt        <= 3'h0;
      wr         <= 1'b0;
      flash_addr <= 20'h00000;
      dq_out     <= 16'h0000;
      rdata      <= 16'h0000;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      wr         <= next_wr;
      flash_addr <= next_flash_addr;
      dq_out     <= next_dq_out;
      rdata      <= next_rdata;
    end
  end

endmodule : bbf_bus_cycle

// *** verilog/bbf_host.sv ***
`timescale 1ns/100ps
// Behaviour
// R1: Any address inside a block selects that block for erase.
// R2: Bottom-boot word map puts boot block at 00000h-01FFFh.
// R3: Top-boot word map puts boot block at 7E000h-7FFFFh.
// R4: Bottom-boot byte map puts boot block at 00000h-03FFFh.
// R5: Top-boot byte map puts boot block at FC000h-FFFFFh.
// R6: Supply at or below lockout level locks every block.
// R7: Reset/power-down low resets device, locks all, forbids reads.
// R8: With reset high, write-protect low guards only boot block.
// R9: High-voltage reset/power-down level unlocks all blocks.
// R10: 12-volt variants ignore write-protect; unlock only at high voltage.
// R11: While a job runs only status reads are accepted; the code also accepts suspend while an erase runs.
// R12: Device powers up in read-array; mode changes need a command.
// R13: Commands go on the low data byte; upper byte ignored.
// R14: FFh read array, 70h read status, 50h clear status.
// R15: 90h enters identity mode; address lsb selects the code.
// R16: Program is 40h or 10h then data, both at same address.
// R17: Erase is 20h then D0h, both inside the same block.
// R18: B0h suspends an erase, D0h resumes it, any address.
// R19: Status bits 0-7 appear on data lines 0-7.
// R20: Parameter blocks get no write-protect locking.
// R21: Eight main blocks, seven 128K and one 96K bytes.
// R22: Ready flag 1 means ready; other bits valid only then.
// R23: Suspend sets suspend and ready flags until resume.
// R24: Failed erase or program sets the matching error flag.
// R25: Status latched at later falling strobe edge of the read.
// R26: Clear status resets the error flags.
module bbf_host
  import bbf_pkg::*;
(
  input  logic        ref_clk,
  input  logic        rst,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  output logic        ce_n,
  output logic        oe_n,
  output logic        we_n,
  output logic [19:0] flash_addr,
  output logic [15:0] dq_out,
  output logic        dq_oe,
  input  logic [15:0] dq_in,
  output logic        reset_powerdown_n,
  output logic        high_voltage_en,
  output logic        write_protect_n,
  input  logic        vpp_ok
);

  bbf_main_e   state;
  bbf_main_e   next_state;
  logic [3:0]  op;
  logic [3:0]  next_op;
  logic [19:0] addr_reg;
  logic [19:0] next_addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] next_wdata_reg;
  logic [5:0]  cfg;
  logic [5:0]  next_cfg;
  logic [15:0] rdata_reg;
  logic [15:0] next_rdata_reg;
  logic [7:0]  status_byte;
  logic [7:0]  next_status_byte;
  logic        job_active;
  logic        next_job_active;
  logic        job_erase;
  logic        next_job_erase;
  logic        refused;
  logic        next_refused;
  logic        locked_refused;
  logic        next_locked_refused;
  logic        launched;
  logic        next_launched;
  logic        vpp_meta;
  logic        vpp_sync;
  logic        cy_start;
  logic        cy_write;
  logic [19:0] cy_addr;
  logic [15:0] cy_wdata;
  logic        cy_done;
  logic [15:0] cy_rdata;
  logic        wr_acc;
  logic [3:0]  req_op;
  logic [7:0]  first_code;
  logic        has_second;
  logic        has_read;
  logic        boot_hit;
  logic        target_locked;
  logic        allowed;

  // Configuration drives the protection pins; the high-voltage bit also holds reset/power-down high
  assign reset_powerdown_n = cfg[CFG_RP_N] | cfg[CFG_HV];
  assign high_voltage_en   = cfg[CFG_HV];
  assign write_protect_n   = cfg[CFG_WP_N];

  // Boot-block window for the configured variant and width
  always_comb
  begin
    if (cfg[CFG_TOP])
      boot_hit = cfg[CFG_BYTE] ? (addr_reg >= BOOT_TOP_BYTE_BEG) // R5
               : ((addr_reg & WORD_ADDR_MASK) >= BOOT_TOP_WORD_BEG); // R3
    else
      boot_hit = cfg[CFG_BYTE] ? (addr_reg <= BOOT_BOT_BYTE_END) // R4
               : (addr_reg <= BOOT_BOT_WORD_END); // R2
  end

  // Predict the device lock so doomed jobs never start
  always_comb
  begin
    target_locked = 1'b0;
    if (!vpp_sync)
      target_locked = 1'b1; // R6
    else if (cfg[CFG_HV])
      target_locked = 1'b0; // R9
    else if (!cfg[CFG_RP_N])
      target_locked = 1'b1; // R7
    else if (cfg[CFG_V12])
      target_locked = 1'b1; // R10
    else
      target_locked = boot_hit && !cfg[CFG_WP_N]; // R8 R20
  end

  // Per-operation command plan; programs and erases use one address
  always_comb
  begin
    first_code = CODE_READ_ARRAY;
    has_second = 1'b0;
    has_read   = 1'b0;
    case (op)
      OP_READ_ARRAY:  has_read = 1'b1; // R14
      OP_READ_STATUS:
      begin
        first_code = CODE_READ_STATUS; // R14
        has_read   = 1'b1;
      end
      OP_CLR_STATUS:  first_code = CODE_CLR_STATUS; // R14 R26
      OP_READ_ID:
      begin
        first_code = CODE_READ_ID; // R15
        has_read   = 1'b1;
      end
      OP_PROGRAM:
      begin
        first_code = CODE_PROGRAM; // R16
        has_second = 1'b1;
      end
      OP_ERASE:
      begin
        first_code = CODE_ERASE; // R17 R1 R21
        has_second = 1'b1;
      end
      OP_SUSPEND:     first_code = CODE_SUSPEND; // R18
      OP_RESUME:      first_code = CODE_CONFIRM; // R18
      default:        first_code = CODE_READ_ARRAY;
    endcase
  end

  // Bus-cycle request; suspend and resume use address zero
  always_comb
  begin
    cy_start = (state != M_IDLE) && !launched;
    cy_write = (state != M_RD);
    cy_addr  = (op == OP_SUSPEND || op == OP_RESUME) ? 20'h00000 : addr_reg;
    cy_wdata = {8'h00, first_code}; // R13
    if (state == M_WR2)
      cy_wdata = (op == OP_ERASE) ? {8'h00, CODE_CONFIRM} : wdata_reg;
  end

  // Acceptance of a new operation
  always_comb
  begin
    wr_acc  = psel && penable && pwrite && (paddr == REG_CMD);
    req_op  = pwdata[3:0];
    allowed = cfg[CFG_RP_N] || cfg[CFG_HV]; // R7
    if (job_active) // R11
      allowed = allowed && (req_op == OP_READ_STATUS ||
                            (req_op == OP_SUSPEND && job_erase));
  end

  // Controller next-state and register-file updates
  always_comb
  begin
    next_state          = state;
    next_op             = op;
    next_addr_reg       = addr_reg;
    next_wdata_reg      = wdata_reg;
    next_cfg            = cfg;
    next_rdata_reg      = rdata_reg;
    next_status_byte    = status_byte;
    next_job_active     = job_active;
    next_job_erase      = job_erase;
    next_refused        = refused;
    next_locked_refused = locked_refused;
    next_launched       = launched;
    if (psel && penable && pwrite && state == M_IDLE)
    begin
      if (paddr == REG_ADDR)
        next_addr_reg = pwdata[19:0];
      if (paddr == REG_WDATA)
        next_wdata_reg = pwdata[15:0];
      if (paddr == REG_CONFIG)
        next_cfg = pwdata[CFG_W-1:0];
    end
    // Write-one clears; a same-cycle set below wins
    if (psel && penable && pwrite && paddr == REG_STATUS)
    begin
      next_refused        = refused & !pwdata[ST_REFUSED];
      next_locked_refused = locked_refused & !pwdata[ST_LOCKED];
    end
    if (cy_start)
      next_launched = 1'b1;
    case (state)
      M_IDLE:
        if (wr_acc)
        begin
          if (!allowed || req_op == 4'h0 || req_op > OP_RESUME)
            next_refused = 1'b1;
          else if ((req_op == OP_PROGRAM || req_op == OP_ERASE) && target_locked)
            next_locked_refused = 1'b1;
          else
          begin
            next_op    = req_op;
            next_state = M_WR1;
          end
        end
      M_WR1:
        if (cy_done)
        begin
          next_launched = 1'b0;
          next_state    = has_second ? M_WR2 : (has_read ? M_RD : M_IDLE);
          if (op == OP_RESUME)
            next_job_active = 1'b1; // R23
        end
      M_WR2:
        if (cy_done)
        begin
          next_launched   = 1'b0;
          next_state      = M_IDLE;
          next_job_active = 1'b1;
          next_job_erase  = (op == OP_ERASE);
        end
      M_RD:
        if (cy_done)
        begin
          next_launched  = 1'b0;
          next_state     = M_IDLE;
          next_rdata_reg = cy_rdata;
          if (op == OP_READ_STATUS)
          begin
            next_status_byte = cy_rdata[7:0]; // R19 R25 R24
            if (cy_rdata[READY_BIT]) // R22 R11
              next_job_active = 1'b0;
          end
        end
      default:
        next_state = M_IDLE;
    endcase
  end

  // Register read mux; unmapped offsets answer with an error
  always_comb
  begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = 32'h00000000;
    case (paddr)
      REG_CMD:    prdata = {28'h0000000, op};
      REG_ADDR:   prdata = {12'h000, addr_reg};
      REG_WDATA:  prdata = {16'h0000, wdata_reg};
      REG_CONFIG: prdata = {26'h0000000, cfg};
      REG_STATUS: prdata = {16'h0000, status_byte, 4'h0, locked_refused, refused,
                            job_active, (state != M_IDLE)};
      REG_RDATA:  prdata = {16'h0000, rdata_reg};
      default:    pslverr = psel && penable;
    endcase
  end

  // State registers; device wakes in read-array so none is forced
  always_ff @(posedge ref_clk)
  begin
    vpp_meta <= vpp_ok;
    vpp_sync <= vpp_meta;
    if (rst)
    begin
      state          <= M_IDLE; // R12
      op             <= 4'h0;
      addr_reg       <= 20'h00000;
      wdata_reg      <= 16'h0000;
      cfg            <= CFG_RESET;
      rdata_reg      <= 16'h0000;
      status_byte    <= 8'h00;
      job_active     <= 1'b0;
      job_erase      <= 1'b0;
      refused        <= 1'b0;
      locked_refused <= 1'b0;
      launched       <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      op             <= next_op;
      addr_reg       <= next_addr_reg;
      wdata_reg      <= next_wdata_reg;
      cfg            <= next_cfg;
      rdata_reg      <= next_rdata_reg;
      status_byte    <= next_status_byte;
      job_active     <= next_job_active;
      job_erase      <= next_job_erase;
      refused        <= next_refused;
      locked_refused <= next_locked_refused;
      launched       <= next_launched;
    end
  end

  // Pin-level bus cycle engine
  bbf_bus_cycle u_cycle (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .start      (cy_start),
    .write      (cy_write),
    .addr       (cy_addr),
    .wdata      (cy_wdata),
    .done       (cy_done),
    .rdata      (cy_rdata),
    .ce_n       (ce_n),
    .oe_n       (oe_n),
    .we_n       (we_n),
    .flash_addr (flash_addr),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .dq_in      (dq_in)
  );

endmodule : bbf_host

// *** bench/bbf_host_props.sv ***
`timescale 1ns/100ps
module bbf_host_props
  import bbf_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [19:0] flash_addr,
  input wire logic        dq_oe,
  input wire logic        reset_powerdown_n,
  input wire logic        high_voltage_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Offsets that the register map decodes
  logic mapped;
  assign mapped = paddr inside {REG_CMD, REG_ADDR, REG_WDATA, REG_CONFIG, REG_STATUS, REG_RDATA};

  a_rst_idle: assert property ($fell(rst) |-> ce_n && oe_n && we_n && !dq_oe
    && !reset_powerdown_n && !high_voltage_en) else $error("pins not idle after reset");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response wrong");
  a_we_pulse: assert property ($fell(we_n) |-> !we_n[*2] ##1 we_n)
    else $error("write strobe length wrong");
  a_oe_pulse: assert property ($fell(oe_n) |-> !oe_n[*4] ##1 oe_n)
    else $error("read strobe length wrong");
  a_ce_strobe: assert property (!we_n || !oe_n |-> !ce_n && (oe_n || we_n))
    else $error("strobes out of step");
  a_addr_held: assert property (!ce_n |-> $stable(flash_addr))
    else $error("address moved in strobe");
  a_read_nodrive: assert property (!oe_n |-> !dq_oe)
    else $error("host drives data in read");
  a_hold_dq: assert property ($rose(we_n) |-> dq_oe && ce_n)
    else $error("data dropped in hold");
  a_hv_rp: assert property (high_voltage_en |-> reset_powerdown_n)
    else $error("high voltage without reset high");
  a_pd_quiet: assert property (!reset_powerdown_n |-> ce_n && !dq_oe)
    else $error("flash cycle in power-down");
  c_write: cover property ($fell(we_n));
  c_read: cover property ($fell(oe_n));
  c_slverr: cover property (psel && penable && pslverr);
endmodule : bbf_host_props

bind bbf_host bbf_host_props chk_u (.ref_clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
  .ce_n, .oe_n, .we_n, .flash_addr, .dq_oe, .reset_powerdown_n, .high_voltage_en);

// *** bench/bbf_flash_model.sv ***
`timescale 1ns/100ps
module bbf_flash_model
  import bbf_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h005a, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h00a5, // Arbitrary value
  parameter int          BUSY_RDS = 2
)(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [19:0] flash_addr,
  input  wire logic [15:0] dq_out,
  output logic [15:0]      dq_in,
  input  wire logic        reset_powerdown_n,
  input  wire logic        high_voltage_en,
  input  wire logic        write_protect_n,
  input  wire logic        vpp_ok
);
  logic [15:0] mem [int];
  logic [7:0]  pend;
  logic [7:0]  cmd;
  logic [7:0]  sts = 8'h80;
  logic [1:0]  mode = 2'd0;
  logic        erasing = 1'b0;
  logic [15:0] rd_q = 16'h0;
  int          busy = 0;

  function automatic logic [15:0] rd_mem(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : rd_mem

  // Bottom word map only; parameter blocks never see write-protect
  function automatic logic lock_at(input logic [19:0] a);
    if (!vpp_ok || !reset_powerdown_n) return 1'b1;
    if (high_voltage_en) return 1'b0;
    return !write_protect_n && a <= BOOT_BOT_WORD_END;
  endfunction : lock_at

  // Command decode at the write strobe
  always @(negedge we_n)
    if (reset_powerdown_n)
    begin
      cmd = dq_out[7:0];
      if (pend == CODE_PROGRAM || pend == 8'h10)
      begin
        if (!lock_at(flash_addr)) mem[flash_addr] = rd_mem(flash_addr) & dq_out;
        if (lock_at(flash_addr) || rd_mem(flash_addr) !== dq_out) sts[PROG_ERR_BIT] = 1'b1;
        busy = BUSY_RDS;
      end
      else if (pend == CODE_ERASE && cmd == CODE_CONFIRM)
      begin
        if (lock_at(flash_addr)) sts[ERASE_ERR_BIT] = 1'b1;
        busy = BUSY_RDS;
        erasing = 1'b1;
      end
      else if (busy > 0 && erasing && cmd == CODE_SUSPEND)
      begin
        sts[SUSPEND_BIT] = 1'b1;
        busy = 0;
      end
      else if (sts[SUSPEND_BIT] && cmd == CODE_CONFIRM)
      begin
        sts[SUSPEND_BIT] = 1'b0;
        busy = BUSY_RDS;
      end
      else if (busy == 0)
        case (cmd)
          CODE_READ_ARRAY: mode = 2'd0;
          CODE_READ_ID:    mode = 2'd2;
          CODE_CLR_STATUS: sts[5:3] = 3'h0;
          default:         mode = 2'd1;
        endcase
      pend = (busy == 0 && sts[SUSPEND_BIT] == 1'b0) ? cmd : 8'h00;
      if (busy > 0) pend = 8'h00;
      if (busy > 0) mode = 2'd1;
      sts[READY_BIT] = (busy == 0);
    end

  // Status latched when the later of the two strobes falls
  always @(negedge (ce_n | oe_n))
  begin
    rd_q = (mode == 2'd1) ? {8'h00, sts} : (mode == 2'd2) ?
      (flash_addr[0] ? DEV_CODE : MFR_CODE) : rd_mem(flash_addr);
    if (mode == 2'd1 && busy > 0) busy = busy - 1;
    if (busy == 0) erasing = erasing && sts[SUSPEND_BIT];
    sts[READY_BIT] = (busy == 0);
  end

  // Released bus shows the inverse, never a stale copy
  assign dq_in = (!ce_n && !oe_n && reset_powerdown_n) ? rd_q : ~rd_q;
endmodule : bbf_flash_model

// *** bench/boot_block_flash_command_interface_tb.sv ***
`timescale 1ns/100ps
module boot_block_flash_command_interface_tb
  import bbf_pkg::*;
;
  localparam logic [15:0] MFR = 16'h005a; // Arbitrary value
  localparam logic [15:0] DEV = 16'h00a5; // Arbitrary value
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, vpp_ok, err;
  logic        ce_n, oe_n, we_n, dq_oe, rp_n, hv, wp_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [19:0] flash_addr;
  logic [15:0] dq_out, dq_in;
  int          n_errors = 0;
  int          n_checks = 0;
  // Lock table: config, address, supply good, expected lock
  logic [5:0]  t_cfg [10] = '{6'h03, 6'h01, 6'h01, 6'h05, 6'h23, 6'h03, 6'h09, 6'h19, 6'h11, 6'h01};
  logic [19:0] t_adr [10] = '{20'h0, 20'h0, 20'h2000, 20'h0, 20'h2000, 20'h2000, 20'h7e000,
                              20'hfc000, 20'h03fff, 20'h01fff};
  logic        t_vpp [10] = '{1, 1, 1, 1, 1, 0, 1, 1, 1, 1};
  logic        t_lck [10] = '{0, 1, 0, 0, 1, 1, 1, 1, 1, 1};

  bbf_host dut_u (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ce_n, .oe_n, .we_n, .flash_addr, .dq_out, .dq_oe, .dq_in,
    .reset_powerdown_n(rp_n), .high_voltage_en(hv), .write_protect_n(wp_n), .vpp_ok);
  bbf_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .BUSY_RDS(2)) flash_u (.ce_n, .oe_n, .we_n,
    .flash_addr, .dq_out, .dq_in, .reset_powerdown_n(rp_n), .high_voltage_en(hv),
    .write_protect_n(wp_n), .vpp_ok);

  always #50 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No cycle count assumed; a stalled slave is left to the watchdog
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  // Issue an operation and wait for the flash cycles to end
  task automatic op(input logic [3:0] o);
    apb(1'b1, REG_CMD, {28'h0, o});
    do apb(1'b0, REG_STATUS, 32'h0); while (q[ST_BUSY] !== 1'b0);
  endtask : op

  // Status reads until the device reports ready, at most ten tries
  task automatic poll();
    int n;
    n = 0;
    do
    begin
      op(OP_READ_STATUS);
      apb(1'b0, REG_STATUS, 32'h0);
    end
    while (q[15] !== 1'b1 && ++n < 10);
  endtask : poll

  initial
  begin
    ref_clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; vpp_ok = 1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, REG_CONFIG, 32'h0); chk(q, 32'h0);
    apb(1'b0, 8'h40, 32'h0); chk(err, 1'b1);
    op(OP_READ_ARRAY); chk(q[ST_REFUSED], 1'b1);
    apb(1'b1, REG_STATUS, 32'h4);
    apb(1'b1, REG_CONFIG, 32'h3);
    apb(1'b1, REG_ADDR, 32'h100);
    op(OP_READ_ARRAY); apb(1'b0, REG_RDATA, 32'h0); chk(q[15:0], 16'hffff);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, REG_ADDR, i);
      op(OP_READ_ID); apb(1'b0, REG_RDATA, 32'h0); chk(q[15:0], i ? DEV : MFR);
    end
    apb(1'b1, REG_ADDR, 32'h100);
    apb(1'b1, REG_WDATA, 32'h1234);
    op(OP_PROGRAM);
    op(OP_READ_ARRAY); chk(q[ST_REFUSED], 1'b1);
    apb(1'b1, REG_STATUS, 32'h4);
    poll(); chk(q[15:8], 8'h80);
    op(OP_READ_ARRAY); apb(1'b0, REG_RDATA, 32'h0); chk(q[15:0], 16'h1234);
    apb(1'b1, REG_WDATA, 32'hffff);
    op(OP_PROGRAM); poll(); chk(q[15:8], 8'h90);
    op(OP_CLR_STATUS); poll(); chk(q[15:8], 8'h80);
    apb(1'b1, REG_ADDR, 32'h20000);
    op(OP_ERASE); op(OP_SUSPEND);
    op(OP_READ_STATUS); apb(1'b0, REG_STATUS, 32'h0); chk(q[15:8], 8'hc0);
    op(OP_RESUME); poll(); chk(q[15:8], 8'h80);
    for (int i = 0; i < 10; i++)
    begin
      vpp_ok <= t_vpp[i];
      apb(1'b1, REG_CONFIG, t_cfg[i]);
      apb(1'b1, REG_ADDR, t_adr[i]);
      apb(1'b1, REG_WDATA, 32'h00ff);
      op(OP_PROGRAM); chk(q[ST_LOCKED], t_lck[i]);
      if (!t_lck[i])
      begin
        poll(); chk(q[15:8], 8'h80);
      end
      apb(1'b1, REG_STATUS, 32'hc);
    end
    complete_run();
  end

  // Whole run needs under a thousand cycles; this allows fifty thousand
  initial
  begin
    #(5_000_000);
    n_errors++;
    complete_run();
  end
endmodule : boot_block_flash_command_interface_tb
